// >>> src/bsr_pkg.sv
// bsr_pkg: constants and carrier types of the sensor serial readout
//What this block does
//- sample command, update output on rising clock
//- output carries data, else conversion status
//- three high bits open every command
//- three low bits close the selection field
//- four-bit field selects conversion or word
//- conversion start acknowledged by output rising
//- output falls when the conversion finishes
//- seventeen clocks shift the sixteen-bit result out
//- readout may pause, position is kept
//- 21-bit pattern returns link to idle anywhere
//- 64 calibration bits as four words
//- word layout of first, fifth, sixth coefficient
//- word layout of fourth, third, second coefficient
//- one converter gives pressure and temperature values
package bsr_pkg;
	localparam logic [4:0] START_LAST = 5'h2;
	localparam logic [4:0] SEL_LAST = 5'h3;
	localparam logic [4:0] STOP_LAST = 5'h2;
	localparam logic [4:0] ACK_LAST = 5'h1;
	localparam logic [4:0] READ_LAST = 5'h10;
	localparam int RST_BITS = 21;
	localparam logic [20:0] RST_PATTERN = 21'h15_5540;
	localparam logic [3:0] SEL_PRESS = 4'h1;
	localparam logic [3:0] SEL_TEMP = 4'h2;
	localparam logic [3:0] SEL_CALIBRATION_WORD_ONE = 4'h3;
	localparam logic [3:0] SEL_CALIBRATION_WORD_TWO = 4'h4;
	localparam logic [3:0] SEL_CALIBRATION_WORD_THREE = 4'h5;
	localparam logic [3:0] SEL_CALIBRATION_WORD_FOUR = 4'h6;
	localparam int CONV_TIME_MS = 35;
	localparam int CORE_CLK_MHZ = 250;
	localparam int CONV_CYCLES = CONV_TIME_MS * CORE_CLK_MHZ * 1000;
	localparam logic [15:0] WORD_RESET = 16'h0000;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_SEL = 3'b001,
		ST_STOP = 3'b010,
		ST_ACK = 3'b011,
		ST_WAIT = 3'b100,
		ST_READ = 3'b101
	} bsr_state_t;

	typedef struct packed
	{
		logic [14:0] first_coefficient;
		logic [11:0] second_coefficient;
		logic [9:0] third_coefficient;
		logic [9:0] fourth_coefficient;
		logic [10:0] fifth_coefficient;
		logic [5:0] sixth_coefficient;
	} bsr_coef_t;

	typedef struct packed
	{
		logic [15:0] w1;
		logic [15:0] w2;
		logic [15:0] w3;
		logic [15:0] w4;
	} bsr_cal_t;
endpackage

// >>> src/bsr_readout.sv
// bsr_readout: three-wire serial readout of the pressure and temperature sensor
`timescale 1ns/10ps
`default_nettype none
module bsr_readout
#(
	parameter int unsigned CONV_CYCLES = bsr_pkg::CONV_CYCLES,
	parameter bsr_pkg::bsr_coef_t COEF = 64'h0000_0000_0000_0000
)
(
	// core side
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic [15:0] i_raw_pressure_value,
	input wire logic [15:0] i_raw_temperature_value,
	// serial link
	input wire logic i_sclk,
	input wire logic i_din,
	output logic o_dout
);
	localparam int CW = $clog2(CONV_CYCLES + 1);
	localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);

	bsr_pkg::bsr_cal_t cal;
	bsr_pkg::bsr_state_t state_q;
	logic [4:0] cnt_q;
	logic [3:0] sel_q;
	logic [15:0] shift_q;
	logic ldout_q;
	logic start_tgl_q;
	logic temp_sel_q;
	logic lrst_s1_q;
	logic lrst_s2_q;
	logic [19:0] rpat_q;
	logic rst_hit;
	logic [15:0] result_q;
	logic busy_q;
	logic conv_temp_q;
	logic [CW-1:0] ccnt_q;
	logic tgl_s1_q;
	logic tgl_s2_q;
	logic tgl_s3_q;
	logic ld_s1_q;
	logic ld_s2_q;
	logic o_dout_q;
	logic start_pulse;

	// factory words; the fifth and second coefficients are split across word boundaries
	assign cal.w1 = {COEF.first_coefficient, COEF.fifth_coefficient[10]};
	assign cal.w2 = {COEF.fifth_coefficient[9:0], COEF.sixth_coefficient};
	assign cal.w3 = {COEF.fourth_coefficient, COEF.second_coefficient[11:6]};
	assign cal.w4 = {COEF.third_coefficient, COEF.second_coefficient[5:0]};

	// link reset follows the core reset two link clock edges later; the link clock must run for it to take effect
	always_ff @(posedge i_sclk)
	begin
		lrst_s1_q <= i_rst_b;
		lrst_s2_q <= lrst_s1_q;
	end

	// pattern is seen in every state, including mid-readout
	always_ff @(posedge i_sclk)
	begin
		if (!lrst_s2_q)
			rpat_q <= 20'h0_0000;
		else
			rpat_q <= {rpat_q[18:0], i_din};
	end
	assign rst_hit = ({rpat_q, i_din} == bsr_pkg::RST_PATTERN);

	// link side: all on the rising serial clock edge, the host never gets a clock from us
	always_ff @(posedge i_sclk)
	begin
		if (!lrst_s2_q || rst_hit)
		begin
			state_q <= bsr_pkg::ST_IDLE;
			cnt_q <= 5'h0;
			sel_q <= 4'h0;
			shift_q <= bsr_pkg::WORD_RESET;
			ldout_q <= 1'b0;
			if (!lrst_s2_q)
			begin
				start_tgl_q <= 1'b0;
				temp_sel_q <= 1'b0;
			end
		end
		else
		begin
			unique case (state_q)
				bsr_pkg::ST_IDLE:
				begin
					if (i_din && cnt_q == bsr_pkg::START_LAST)
					begin
						state_q <= bsr_pkg::ST_SEL;
						cnt_q <= 5'h0;
					end
					else if (i_din)
						cnt_q <= cnt_q + 5'h1;
					else
						cnt_q <= 5'h0;
				end
				bsr_pkg::ST_SEL:
				begin
					sel_q <= {sel_q[2:0], i_din};
					if (cnt_q == bsr_pkg::SEL_LAST)
					begin
						state_q <= bsr_pkg::ST_STOP;
						cnt_q <= 5'h0;
					end
					else
						cnt_q <= cnt_q + 5'h1;
				end
				bsr_pkg::ST_STOP:
				begin
					if (i_din)
					begin
						state_q <= bsr_pkg::ST_IDLE;
						cnt_q <= 5'h0;
					end
					else if (cnt_q != bsr_pkg::STOP_LAST)
						cnt_q <= cnt_q + 5'h1;
					else
					begin
						cnt_q <= 5'h0;
						unique case (sel_q)
							bsr_pkg::SEL_PRESS, bsr_pkg::SEL_TEMP:
							begin
								state_q <= bsr_pkg::ST_ACK;
								ldout_q <= 1'b1;
								start_tgl_q <= ~start_tgl_q;
								temp_sel_q <= (sel_q == bsr_pkg::SEL_TEMP);
							end
							bsr_pkg::SEL_CALIBRATION_WORD_ONE:
							begin
								state_q <= bsr_pkg::ST_READ;
								shift_q <= cal.w1;
							end
							bsr_pkg::SEL_CALIBRATION_WORD_TWO:
							begin
								state_q <= bsr_pkg::ST_READ;
								shift_q <= cal.w2;
							end
							bsr_pkg::SEL_CALIBRATION_WORD_THREE:
							begin
								state_q <= bsr_pkg::ST_READ;
								shift_q <= cal.w3;
							end
							bsr_pkg::SEL_CALIBRATION_WORD_FOUR:
							begin
								state_q <= bsr_pkg::ST_READ;
								shift_q <= cal.w4;
							end
							default:
								state_q <= bsr_pkg::ST_IDLE;
						endcase
					end
				end
				bsr_pkg::ST_ACK:
				begin
					// two clocks after the acknowledge, then the core holds the line
					if (cnt_q == bsr_pkg::ACK_LAST)
					begin
						state_q <= bsr_pkg::ST_WAIT;
						ldout_q <= 1'b0;
						cnt_q <= 5'h0;
					end
					else
						cnt_q <= cnt_q + 5'h1;
				end
				bsr_pkg::ST_WAIT:
				begin
					// host clocks again only after the end of conversion,
					// so result_q is stable here and is taken without a synchroniser
					ldout_q <= result_q[15];
					shift_q <= {result_q[14:0], 1'b0};
					cnt_q <= 5'h1;
					state_q <= bsr_pkg::ST_READ;
				end
				bsr_pkg::ST_READ:
				begin
					// no edge means no move: a held clock pauses the readout
					if (cnt_q == bsr_pkg::READ_LAST)
					begin
						ldout_q <= 1'b0;
						cnt_q <= 5'h0;
						state_q <= bsr_pkg::ST_IDLE;
					end
					else
					begin
						ldout_q <= shift_q[15];
						shift_q <= {shift_q[14:0], 1'b0};
						cnt_q <= cnt_q + 5'h1;
					end
				end
				default:
					state_q <= bsr_pkg::ST_IDLE;
			endcase
		end
	end

	// crossings into the core domain
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_b)
		begin
			tgl_s1_q <= 1'b0;
			tgl_s2_q <= 1'b0;
			tgl_s3_q <= 1'b0;
			ld_s1_q <= 1'b0;
			ld_s2_q <= 1'b0;
		end
		else
		begin
			tgl_s1_q <= start_tgl_q;
			tgl_s2_q <= tgl_s1_q;
			tgl_s3_q <= tgl_s2_q;
			ld_s1_q <= ldout_q;
			ld_s2_q <= ld_s1_q;
		end
	end
	assign start_pulse = tgl_s2_q ^ tgl_s3_q;

	// one shared converter; a link reset does not abort a running conversion
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_b)
		begin
			busy_q <= 1'b0;
			ccnt_q <= '0;
			conv_temp_q <= 1'b0;
			result_q <= bsr_pkg::WORD_RESET;
		end
		else if (start_pulse && !busy_q)
		begin
			busy_q <= 1'b1;
			ccnt_q <= '0;
			conv_temp_q <= temp_sel_q;
		end
		else if (busy_q && ccnt_q == CONV_LAST)
		begin
			busy_q <= 1'b0;
			result_q <= conv_temp_q ? i_raw_temperature_value : i_raw_pressure_value;
		end
		else if (busy_q)
			ccnt_q <= ccnt_q + CW'(1);
	end

	// status overrides link data while converting
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_b)
			o_dout_q <= 1'b0;
		else
			o_dout_q <= busy_q | ld_s2_q;
	end
	assign o_dout = o_dout_q;

	property p_start;
		@(posedge i_sclk) disable iff (!lrst_s2_q)
		(state_q == bsr_pkg::ST_IDLE && cnt_q == bsr_pkg::START_LAST && i_din && !rst_hit)
		|=> state_q == bsr_pkg::ST_SEL;
	endproperty
	a_start: assert property (p_start) else $error("start marker not taken");

	property p_sel;
		@(posedge i_sclk) disable iff (!lrst_s2_q || rst_hit)
		(state_q == bsr_pkg::ST_SEL && cnt_q == bsr_pkg::SEL_LAST) |=> state_q == bsr_pkg::ST_STOP;
	endproperty
	a_sel: assert property (p_sel) else $error("selection field length wrong");

	property p_stop_bad;
		@(posedge i_sclk) disable iff (!lrst_s2_q)
		(state_q == bsr_pkg::ST_STOP && i_din && !rst_hit) |=> state_q == bsr_pkg::ST_IDLE;
	endproperty
	a_stop_bad: assert property (p_stop_bad) else $error("broken stop marker accepted");

	property p_ack;
		@(posedge i_sclk) disable iff (!lrst_s2_q)
		(state_q == bsr_pkg::ST_STOP && cnt_q == bsr_pkg::STOP_LAST && !i_din && !rst_hit
		&& (sel_q == bsr_pkg::SEL_PRESS || sel_q == bsr_pkg::SEL_TEMP))
		|=> ldout_q && $changed(start_tgl_q) ##1 ldout_q;
	endproperty
	a_ack: assert property (p_ack) else $error("no conversion acknowledge");

	property p_done;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(busy_q && ccnt_q == CONV_LAST) |-> ##2 o_dout_q == $past(ld_s2_q);
	endproperty
	a_done: assert property (p_done) else $error("output did not fall at conversion end");

	property p_busy_high;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		busy_q |=> o_dout_q;
	endproperty
	a_busy_high: assert property (p_busy_high) else $error("status low while converting");

	property p_shift;
		@(posedge i_sclk) disable iff (!lrst_s2_q || rst_hit)
		(state_q == bsr_pkg::ST_READ && cnt_q != bsr_pkg::READ_LAST) |=> ldout_q == $past(shift_q[15]);
	endproperty
	a_shift: assert property (p_shift) else $error("wrong readout bit");

	property p_read_end;
		@(posedge i_sclk) disable iff (!lrst_s2_q || rst_hit)
		(state_q == bsr_pkg::ST_READ && cnt_q == bsr_pkg::READ_LAST) |=> state_q == bsr_pkg::ST_IDLE && !ldout_q;
	endproperty
	a_read_end: assert property (p_read_end) else $error("readout not ended after 17 clocks");

	property p_rst_pat;
		@(posedge i_sclk) disable iff (!lrst_s2_q)
		rst_hit |=> state_q == bsr_pkg::ST_IDLE && cnt_q == 5'h0 && !ldout_q;
	endproperty
	a_rst_pat: assert property (p_rst_pat) else $error("reset pattern ignored");

	property p_result;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(busy_q && ccnt_q == CONV_LAST)
		|=> result_q == ($past(conv_temp_q) ? $past(i_raw_temperature_value) : $past(i_raw_pressure_value));
	endproperty
	a_result: assert property (p_result) else $error("wrong raw value latched");

	property p_c_conv;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		$fell(busy_q);
	endproperty
	c_conv: cover property (p_c_conv);

	property p_c_cal;
		@(posedge i_sclk) disable iff (!lrst_s2_q)
		state_q == bsr_pkg::ST_STOP ##1 state_q == bsr_pkg::ST_READ;
	endproperty
	c_cal: cover property (p_c_cal);

	property p_c_rst;
		@(posedge i_sclk) disable iff (!lrst_s2_q)
		rst_hit && state_q != bsr_pkg::ST_IDLE;
	endproperty
	c_rst: cover property (p_c_rst);

	property p_c_read;
		@(posedge i_sclk) disable iff (!lrst_s2_q)
		state_q == bsr_pkg::ST_WAIT ##1 state_q == bsr_pkg::ST_READ;
	endproperty
	c_read: cover property (p_c_read);
endmodule
`default_nettype wire

// >>> tb/bsr_host_model.sv
// host model that clocks the serial link and sends commands
`timescale 1ns/10ps
`default_nettype none
module bsr_host_model
(
	// serial link
	output logic o_sclk,
	output logic o_din,
	input wire logic i_dout
);
	// clock idles low between frames
	initial
	begin
		o_sclk = 1'b0;
		o_din = 1'b0;
	end

	// odd offsets keep the rising edges off the core clock edges
	task automatic bit_io(input logic b, output logic d);
		o_din = b;
		#23.3 o_sclk = 1'b1;
		#24.7 o_sclk = 1'b0;
		d = i_dout;
	endtask

	task automatic send(input logic [31:0] v, input int n, output logic d);
		for (int i = n - 1; i >= 0; i--)
			bit_io(v[i], d);
	endtask

	task automatic command(input logic [3:0] sel, input logic [2:0] stp, output logic d);
		send({25'h0, 3'b111, sel}, 7, d);
		send({29'h0, stp}, 3, d);
	endtask

	// dout is not judged while the pattern runs
	task automatic resync(output logic d);
		send({11'h0, bsr_pkg::RST_PATTERN}, bsr_pkg::RST_BITS, d);
	endtask

	task automatic read(input int n, input int hold, output logic [15:0] w, output logic last);
		w = 16'h0000;
		for (int i = 15; i > 15 - n; i--)
		begin
			bit_io(1'b0, w[i]);
			if (i == 8)
				#(hold);
		end
		if (n == 16)
			bit_io(1'b0, last);
	endtask
endmodule
`default_nettype wire

// >>> tb/test_baro_sensor_serial_readout.sv
// self-checking bench of the sensor serial readout
`timescale 1ns/10ps
`default_nettype none
module test_baro_sensor_serial_readout;
	localparam int CONV = 200;
	localparam bsr_pkg::bsr_coef_t COEF = 64'h5A3C_9E17_2B64_D0F1;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [15:0] press = 16'hB2C4;
	logic [15:0] temp = 16'h6D19;
	wire sclk;
	wire din;
	wire dout;
	int num_errors = 0;
	int compares = 0;
	logic [15:0] cal [4];
	logic [15:0] w;
	logic d;

	always #2 core_clk = ~core_clk;

	bsr_readout #(.CONV_CYCLES(CONV), .COEF(COEF)) i_dut
	(
		.i_core_clk(core_clk),
		.i_rst_b(rst_b),
		.i_raw_pressure_value(press),
		.i_raw_temperature_value(temp),
		.i_sclk(sclk),
		.i_din(din),
		.o_dout(dout)
	);

	bsr_host_model i_host
	(
		.o_sclk(sclk),
		.o_din(din),
		.i_dout(dout)
	);

	task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		check_word({15'h0, got}, {15'h0, exp});
	endtask

	task automatic report_and_stop();
		$display("compares=%0d num_errors=%0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic test_cal();
		for (int i = 0; i < 4; i++)
		begin
			i_host.command(bsr_pkg::SEL_CALIBRATION_WORD_ONE + 4'(i), 3'b000, d);
			i_host.read(16, 0, w, d);
			check_word(w, cal[i]);
			check_bit(d, 1'b0);
		end
		$display("test_cal done");
	endtask

	task automatic test_refuse();
		i_host.command(bsr_pkg::SEL_CALIBRATION_WORD_ONE, 3'b010, d);
		i_host.read(16, 0, w, d);
		check_word(w, 16'h0000);
		i_host.command(4'hF, 3'b000, d);
		i_host.read(16, 0, w, d);
		check_word(w, 16'h0000);
		$display("test_refuse done");
	endtask

	task automatic test_conv(input logic [3:0] sel, input int hold);
		int n;
		logic [15:0] exp;
		i_host.resync(d);
		i_host.command(sel, 3'b000, d);
		check_bit(d, 1'b1);
		i_host.send(0, 2, d);
		check_bit(d, 1'b1);
		n = 0;
		// clock held low while polling for the end of conversion
		while (dout !== 1'b0 && n < 2 * CONV)
		begin
			@(negedge core_clk);
			n++;
		end
		check_bit(n > CONV / 2 && n <= CONV, 1'b1);
		if (n >= 2 * CONV)
			report_and_stop();
		exp = (sel == bsr_pkg::SEL_PRESS) ? press : temp;
		// result must be the value latched at the end, not the live input
		@(negedge core_clk);
		press = ~press;
		temp = ~temp;
		i_host.read(16, hold, w, d);
		check_word(w, exp);
		check_bit(d, 1'b0);
		$display("test_conv done");
	endtask

	task automatic test_resync();
		i_host.command(bsr_pkg::SEL_CALIBRATION_WORD_TWO, 3'b000, d);
		i_host.read(5, 0, w, d);
		check_word(w, cal[1] & 16'hF800);
		i_host.resync(d);
		i_host.send(32'h7, 5, d);
		i_host.resync(d);
		i_host.command(bsr_pkg::SEL_CALIBRATION_WORD_THREE, 3'b000, d);
		i_host.read(16, 0, w, d);
		check_word(w, cal[2]);
		$display("test_resync done");
	endtask

	initial
	begin
		cal[0] = {COEF.first_coefficient, COEF.fifth_coefficient[10]};
		cal[1] = {COEF.fifth_coefficient[9:0], COEF.sixth_coefficient};
		cal[2] = {COEF.fourth_coefficient, COEF.second_coefficient[11:6]};
		cal[3] = {COEF.third_coefficient, COEF.second_coefficient[5:0]};
		repeat (10) @(negedge core_clk);
		// link side needs its own edges to see the reset
		i_host.send(0, 3, d);
		@(negedge core_clk);
		rst_b = 1'b1;
		i_host.send(0, 2, d);
		check_bit(dout, 1'b0);
		test_cal();
		test_refuse();
		test_conv(bsr_pkg::SEL_PRESS, 0);
		test_conv(bsr_pkg::SEL_TEMP, 100);
		test_resync();
		report_and_stop();
	end
endmodule
`default_nettype wire
